// >>> design/rirq_nrt.sv
module rirq_nrt #(
  parameter int STEP_CYC = rirq_pkg::NRT_STEP_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clr,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [7:0] wait_val,
  // Timeout pulse
  output logic            expire
);
  import rirq_pkg::*;

  typedef struct packed {
    logic        run;
    logic [15:0] cnt;
    logic [15:0] tgt;
    logic        expire;
  } rirq_nrt_s;

  rirq_nrt_s state_q;
  rirq_nrt_s state_d;

  always_comb begin
    state_d        = state_q;
    state_d.expire = 1'b0;
    if (clr || stop) begin
      state_d.run = 1'b0;
      state_d.cnt = 16'h0000;
    end else if (start && (wait_val != 8'h00)) begin
      // Zero wait value disables the watchdog
      state_d.run = 1'b1;
      state_d.cnt = 16'h0000;
      state_d.tgt = 16'(32'(wait_val) * STEP_CYC);
    end else if (state_q.run) begin
      state_d.cnt = state_q.cnt + 16'h0001;
      if (state_q.cnt == state_q.tgt - 16'h0001) begin
        state_d.run    = 1'b0;
        state_d.expire = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign expire = state_q.expire;

endmodule : rirq_nrt

// >>> design/rirq_pkg.sv
package rirq_pkg;

  // Clock
  localparam int          CLK_NS        = 40;

  // Register offsets on the host register port
  localparam logic [7:0]  ADDR_CTRL     = 8'h01;
  localparam logic [7:0]  ADDR_NRT      = 8'h07;
  localparam logic [7:0]  ADDR_STAT     = 8'h0c;
  localparam logic [7:0]  ADDR_MASK     = 8'h0d;

  // Interrupt status bit positions
  localparam int          ST_TX         = 7;
  localparam int          ST_RX         = 6;
  localparam int          ST_FIFO       = 5;
  localparam int          ST_CRC        = 4;
  localparam int          ST_PAR        = 3;
  localparam int          ST_FRM        = 2;
  localparam int          ST_COL        = 1;
  localparam int          ST_NRSP       = 0;

  // Protocol control bit positions
  localparam int          CTRL_NO_RXCRC = 7;
  localparam int          CTRL_COL7     = 0;

  // Values after reset
  localparam logic [7:0]  STAT_RST      = 8'h00;
  localparam logic [5:0]  MASK_RST      = 6'h3e;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  NRT_RST       = 8'h00;

  // Levels and thresholds
  localparam logic [4:0]  FIFO_HI       = 5'h08;
  localparam logic [4:0]  FIFO_LO       = 5'h04;
  localparam logic [3:0]  COL_THR_LO    = 4'h6;
  localparam logic [3:0]  COL_THR_HI    = 4'h7;

  // No-response wait step
  localparam int          NRT_STEP_NS   = 2000;
  localparam int          NRT_STEP_CYC  = (NRT_STEP_NS + CLK_NS - 1) / CLK_NS;

endpackage : rirq_pkg

// >>> design/rirq_sync.sv
module rirq_sync #(
  parameter int           W       = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import rirq_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rirq_sync_s;

  rirq_sync_s state_q;
  rirq_sync_s state_d;

  // First stage feeds only the second one
  always_comb begin
    state_d.s1 = d;
    state_d.s2 = state_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= {RST_VAL, RST_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  assign q = state_q.s2;

endmodule : rirq_sync

// >>> design/rirq_top.sv
module rirq_top #(
  parameter int FIFO_W   = 5,
  parameter int STEP_CYC = rirq_pkg::NRT_STEP_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Device pins
  input  wire logic              por_pin,
  input  wire logic              en_pin,
  // Host register port
  input  wire logic              host_wr,
  input  wire logic              host_rd,
  input  wire logic              host_rd_end,
  input  wire logic [7:0]        host_addr,
  input  wire logic [7:0]        host_wdata,
  output logic      [7:0]        host_rdata,
  // Framing engine events
  input  wire logic              tx_active,
  input  wire logic              rx_active,
  input  wire logic [FIFO_W-1:0] fifo_level,
  input  wire logic              crc_err,
  input  wire logic              parity_err,
  input  wire logic              framing_err,
  input  wire logic              col_strobe,
  input  wire logic [3:0]        col_count,
  // Outputs
  output logic                   irq,
  output logic                   rx_dec_en
);
  import rirq_pkg::*;

  typedef struct packed {
    logic [7:0] status;
    logic [5:0] pend;
    logic [5:0] mask;
    logic [7:0] ctrl;
    logic [7:0] nrt;
    logic       irq;
    logic [7:0] rdata;
    logic [7:0] rd_addr;
    logic       rd_open;
    logic       tx_d;
    logic       rx_d;
    logic       dec_en;
  } rirq_top_s;

  rirq_top_s  state_q;
  rirq_top_s  state_d;

  logic [1:0] pins_s;
  logic       por_s;
  logic       en_s;
  logic       nrt_expire;
  logic       hold_rst;
  logic       wr_ctrl;
  logic       rd_clear;
  logic       clear_all;
  logic       tx_start;
  logic       tx_end;
  logic       rx_start;
  logic       rx_end;
  logic       tx_mid;
  logic       rx_mid;
  logic [3:0] col_thr;
  logic [5:0] rx_ev;
  logic [7:0] rd_mux;

  // Pins cross into the clock domain; chip held off until released
  rirq_sync #(
    .W       (2),
    .RST_VAL (2'b01)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({en_pin, por_pin}),
    .q   (pins_s)
  );

  assign por_s    = pins_s[0];
  assign en_s     = pins_s[1];
  assign hold_rst = por_s || !en_s;

  assign wr_ctrl   = host_wr && (host_addr == ADDR_CTRL);
  assign rd_clear  = host_rd_end && state_q.rd_open && (state_q.rd_addr == ADDR_STAT);
  assign clear_all = wr_ctrl || rd_clear;

  assign tx_start = tx_active && !state_q.tx_d;
  assign tx_end   = !tx_active && state_q.tx_d;
  assign rx_start = rx_active && !state_q.rx_d && !tx_active;
  assign rx_end   = !rx_active && state_q.rx_d;
  assign tx_mid   = tx_active;
  assign rx_mid   = rx_active && !tx_active;

  assign col_thr = state_q.ctrl[CTRL_COL7] ? COL_THR_HI : COL_THR_LO;

  // Receive events, held back until the frame ends
  always_comb begin
    rx_ev          = 6'h00;
    rx_ev[ST_FIFO] = fifo_level > FIFO_W'(FIFO_HI);
    rx_ev[ST_CRC]  = crc_err && !state_q.ctrl[CTRL_NO_RXCRC];
    rx_ev[ST_PAR]  = parity_err;
    rx_ev[ST_FRM]  = framing_err;
    rx_ev[ST_COL]  = col_strobe && (col_count > col_thr);
  end

  // Watchdog armed at transmit end, stopped by start of frame
  rirq_nrt #(
    .STEP_CYC (STEP_CYC)
  ) u_nrt (
    .clk      (clk),
    .rst      (rst),
    .clr      (hold_rst || tx_start),
    .start    (tx_end),
    .stop     (rx_start),
    .wait_val (state_q.nrt),
    .expire   (nrt_expire)
  );

  always_comb begin
    case (host_addr)
      ADDR_CTRL: rd_mux = state_q.ctrl;
      ADDR_NRT:  rd_mux = state_q.nrt;
      ADDR_STAT: rd_mux = state_q.status;
      ADDR_MASK: rd_mux = {2'b00, state_q.mask};
      default:   rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    state_d        = state_q;
    state_d.tx_d   = tx_active;
    state_d.rx_d   = rx_active && !tx_active;
    state_d.dec_en = !tx_active;

    if (host_rd) begin
      state_d.rdata   = rd_mux;
      state_d.rd_addr = host_addr;
      state_d.rd_open = 1'b1;
    end else if (host_rd_end) begin
      state_d.rd_open = 1'b0;
    end

    if (host_wr) begin
      case (host_addr)
        ADDR_CTRL: state_d.ctrl = host_wdata;
        ADDR_NRT:  state_d.nrt  = host_wdata;
        ADDR_MASK: state_d.mask = host_wdata[5:0];
        default:   state_d.ctrl = state_q.ctrl;
      endcase
    end

    // Clears first so that a same-cycle event survives
    if (clear_all) begin
      state_d.status = 8'h00;
      state_d.pend   = 6'h00;
      state_d.irq    = 1'b0;
    end

    if (tx_mid) begin
      if (tx_start) begin
        state_d.status[ST_TX] = 1'b1;
      end
      if (fifo_level < FIFO_W'(FIFO_LO)) begin
        state_d.status[ST_FIFO] = 1'b1;
        if (state_q.mask[ST_FIFO]) begin
          // Immediate so the host can refill before underrun
          state_d.irq = 1'b1;
        end
      end
    end else if (rx_mid) begin
      if (rx_start) begin
        state_d.status[ST_RX] = 1'b1;
      end
      state_d.pend = state_d.pend | rx_ev;
    end

    if (tx_end) begin
      state_d.irq = 1'b1;
    end

    if (rx_end) begin
      state_d.status[5:0] = state_d.status[5:0] | state_d.pend;
      state_d.pend        = 6'h00;
      state_d.irq         = 1'b1;
    end

    if (nrt_expire) begin
      state_d.status[ST_NRSP] = 1'b1;
      if (state_q.mask[ST_NRSP]) begin
        state_d.irq = 1'b1;
      end
    end

    // Pin-level reset overrides register writes and events; read data and edge trackers still update
    if (hold_rst) begin
      state_d.status  = STAT_RST;
      state_d.pend    = 6'h00;
      state_d.mask    = MASK_RST;
      state_d.ctrl    = CTRL_RST;
      state_d.nrt     = NRT_RST;
      state_d.irq     = 1'b0;
      state_d.rd_open = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q        <= '0;
      state_q.mask   <= MASK_RST;
      state_q.ctrl   <= CTRL_RST;
      state_q.nrt    <= NRT_RST;
      state_q.status <= STAT_RST;
      state_q.dec_en <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign host_rdata = state_q.rdata;
  assign irq        = state_q.irq;
  assign rx_dec_en  = state_q.dec_en;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_tx_begin;
    tx_active && !state_q.tx_d && !hold_rst;
  endsequence

  sequence s_rx_begin;
    rx_active && !tx_active && !state_q.rx_d && !hold_rst;
  endsequence

  sequence s_quiet_ctl;
    !clear_all && !hold_rst && !nrt_expire;
  endsequence

  a_pin_reset_zero: assert property (hold_rst |=> (irq == 1'b0) && (state_q.status == 8'h00))
    else $error("status not zero while held in pin reset");

  a_ctrl_wr_clear: assert property (wr_ctrl && !hold_rst && !tx_active && !rx_active
      && !state_q.tx_d && !state_q.rx_d && !nrt_expire |=> state_q.status == 8'h00)
    else $error("control write did not clear status");

  a_read_clear: assert property (rd_clear && !tx_active && !rx_active && !state_q.tx_d && !state_q.rx_d
      && !nrt_expire |=> !irq && (state_q.status[7:1] == 7'h00))
    else $error("status read did not drop request");

  a_tx_flag_early: assert property (s_tx_begin ##0 (!irq && !clear_all) |=> state_q.status[ST_TX]
      && (!irq || state_q.mask[ST_FIFO]))
    else $error("transmit flag wrong at transmit start");

  // A clear right after transmit end may drop the request again
  a_tx_end_irq: assert property (state_q.tx_d && !tx_active && !hold_rst
      |=> irq ##1 (irq || $past(clear_all || hold_rst)))
    else $error("request missing after transmit end");

  a_rx_flag_quiet: assert property (s_rx_begin ##0 s_quiet_ctl ##0 (!irq && !state_q.tx_d)
      |=> state_q.status[ST_RX] && !irq)
    else $error("receive start raised request early");

  a_rx_end_irq: assert property (state_q.rx_d && !rx_active && !tx_active && !hold_rst |=> irq)
    else $error("request missing after receive end");

  a_tx_bits_frozen: assert property (tx_active && state_q.tx_d && !state_q.rx_d ##0 s_quiet_ctl
      |=> {state_q.status[ST_RX], state_q.status[4:0]} == $past({state_q.status[ST_RX],
           state_q.status[4:0]}))
    else $error("status bit changed during transmit");

  a_rx_bits_frozen: assert property (rx_mid && state_q.rx_d && !state_q.tx_d ##0 s_quiet_ctl
      |=> {state_q.status[ST_TX], state_q.status[5:0]} == $past({state_q.status[ST_TX],
           state_q.status[5:0]}) && (irq == $past(irq)))
    else $error("status or request changed during receive");

  a_dec_off_tx: assert property (tx_active && !hold_rst |=> !rx_dec_en)
    else $error("decoder enabled during transmit");

  a_noresp_gate: assert property (nrt_expire && !hold_rst && !state_q.mask[ST_NRSP] && !irq
      && !tx_active && !state_q.tx_d && !state_q.rx_d |=> !irq && state_q.status[ST_NRSP])
    else $error("masked no-response raised request");

  a_irq_hold: assert property (irq && !clear_all && !hold_rst |=> irq)
    else $error("request dropped without clear");

endmodule : rirq_top

// >>> test/reader_irq_status_flags_test.sv
module reader_irq_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rirq_pkg::*;

  logic       clk, rst, por_pin, en_pin;
  logic       tx_active, rx_active, crc_err, parity_err, framing_err, col_strobe;
  logic [4:0] fifo_level;
  logic [3:0] col_count;
  logic       irq, rx_dec_en;
  logic [7:0] rdat;
  logic       host_wr, host_rd, host_rd_end;
  logic [7:0] host_addr, host_wdata, host_rdata;
  int         n_fail, checks;

  rirq_host_model host (
    .clk(clk), .host_wr(host_wr), .host_rd(host_rd), .host_rd_end(host_rd_end),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));

  rirq_top #(.FIFO_W(5), .STEP_CYC(2)) dut (
    .clk(clk), .rst(rst), .por_pin(por_pin), .en_pin(en_pin),
    .host_wr(host_wr), .host_rd(host_rd), .host_rd_end(host_rd_end),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .tx_active(tx_active), .rx_active(rx_active), .fifo_level(fifo_level),
    .crc_err(crc_err), .parity_err(parity_err), .framing_err(framing_err),
    .col_strobe(col_strobe), .col_count(col_count), .irq(irq), .rx_dec_en(rx_dec_en));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task st(input logic [7:0] exp, input logic clr, input string msg);
    host.rd(ADDR_STAT, clr, rdat);
    chk(rdat, exp, msg);
  endtask : st

  task ev(input logic c, input logic p, input logic f, input logic s, input logic [3:0] n);
    @(posedge clk);
    crc_err <= c; parity_err <= p; framing_err <= f; col_strobe <= s; col_count <= n;
    @(posedge clk);
    crc_err <= 1'b0; parity_err <= 1'b0; framing_err <= 1'b0; col_strobe <= 1'b0;
  endtask : ev

  task tx(input logic v);
    @(posedge clk);
    tx_active <= v;
  endtask : tx

  task t_regs;
    st(8'h00, 1'b0, "status reset");
    host.rd(ADDR_MASK, 1'b0, rdat);
    chk(rdat, 8'h3e, "mask reset");
    host.rd(8'h20, 1'b0, rdat);
    chk(rdat, 8'h00, "unmapped read");
    host.wr(ADDR_STAT, 8'hff);
    st(8'h00, 1'b0, "status not writable");
    $display("test regs done");
  endtask : t_regs

  task t_tx;
    tx(1'b1);
    cyc(3);
    st(8'h80, 1'b0, "tx flag at start");
    chk({7'h00, irq}, 8'h00, "no irq during tx");
    ev(1'b1, 1'b1, 1'b1, 1'b1, 4'h8);
    cyc(2);
    st(8'h80, 1'b0, "errors ignored in tx");
    chk({7'h00, rx_dec_en}, 8'h00, "decoder off in tx");
    @(posedge clk) fifo_level <= 5'd3;
    cyc(3);
    st(8'ha0, 1'b0, "fifo low in tx");
    chk({7'h00, irq}, 8'h01, "fifo irq enabled");
    @(posedge clk) fifo_level <= 5'd6;
    tx(1'b0);
    cyc(12);
    chk({7'h00, irq}, 8'h01, "irq held");
    chk({7'h00, rx_dec_en}, 8'h01, "decoder on");
    st(8'ha0, 1'b1, "status before clear");
    chk({7'h00, irq}, 8'h00, "irq dropped by read");
    st(8'h00, 1'b0, "status cleared by read");
    $display("test tx done");
  endtask : t_tx

  task t_rx;
    @(posedge clk) rx_active <= 1'b1;
    cyc(3);
    st(8'h40, 1'b0, "rx flag at start");
    @(posedge clk) fifo_level <= 5'd9;
    ev(1'b1, 1'b1, 1'b1, 1'b1, 4'h7);
    cyc(2);
    st(8'h40, 1'b0, "only rx flag in rx");
    chk({7'h00, irq}, 8'h00, "no irq during rx");
    @(posedge clk) rx_active <= 1'b0;
    fifo_level <= 5'd6;
    cyc(3);
    chk({7'h00, irq}, 8'h01, "irq at rx end");
    st(8'h7e, 1'b0, "error flags at rx end");
    host.wr(ADDR_CTRL, 8'h81);
    cyc(1);
    chk({7'h00, irq}, 8'h00, "ctrl write drops irq");
    st(8'h00, 1'b0, "ctrl write clears");
    @(posedge clk) rx_active <= 1'b1;
    ev(1'b1, 1'b0, 1'b0, 1'b1, 4'h7);
    @(posedge clk) rx_active <= 1'b0;
    cyc(3);
    st(8'h40, 1'b0, "crc skipped, count 7 not above 7");
    host.wr(ADDR_CTRL, 8'h00);
    $display("test rx done");
  endtask : t_rx

  task t_nrsp;
    int i;
    int k;
    // Long wait so the transmit request can be cleared before expiry
    host.wr(ADDR_NRT, 8'h10);
    for (k = 0; k < 2; k++) begin
      if (k == 1) begin
        host.wr(ADDR_MASK, 8'h3f);
        host.rd(ADDR_MASK, 1'b0, rdat);
        chk(rdat, 8'h3f, "mask write");
      end
      tx(1'b1);
      tx(1'b0);
      st(8'h80, 1'b1, "tx flag before no-response");
      chk({7'h00, irq}, 8'h00, "read drops tx irq");
      rdat = 8'h00;
      for (i = 0; i < 30 && rdat[ST_NRSP] !== 1'b1; i++) begin
        host.rd(ADDR_STAT, 1'b0, rdat);
      end
      if (rdat[ST_NRSP] !== 1'b1) begin
        n_fail++;
        $display("FAIL %0t no-response flag never set", $time);
        stop_test;
      end
      chk({7'h00, irq}, (k == 1) ? 8'h01 : 8'h00, "no-response irq follows mask");
      st(8'h01, 1'b1, "no-response flag");
    end
    host.wr(ADDR_NRT, 8'h00);
    $display("test nrsp done");
  endtask : t_nrsp

  task t_pins;
    int k;
    for (k = 0; k < 2; k++) begin
      tx(1'b1);
      tx(1'b0);
      cyc(3);
      chk({7'h00, irq}, 8'h01, "irq after tx end");
      @(posedge clk);
      if (k == 0) por_pin <= 1'b1;
      else en_pin <= 1'b0;
      cyc(5);
      chk({7'h00, irq}, 8'h00, "pin reset drops irq");
      @(posedge clk);
      por_pin <= 1'b0;
      en_pin  <= 1'b1;
      cyc(6);
      st(8'h00, 1'b0, "pin reset clears status");
      host.rd(ADDR_MASK, 1'b0, rdat);
      chk(rdat, 8'h3e, "pin reset restores mask");
    end
    $display("test pins done");
  endtask : t_pins

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("FAIL %0t run timed out", $time);
    stop_test;
  end

  initial begin
    n_fail = 0; checks = 0;
    rst = 1'b1; por_pin = 1'b0; en_pin = 1'b1;
    tx_active = 1'b0; rx_active = 1'b0; fifo_level = 5'd6;
    crc_err = 1'b0; parity_err = 1'b0; framing_err = 1'b0;
    col_strobe = 1'b0; col_count = 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(6);
    t_regs;
    t_tx;
    t_rx;
    t_nrsp;
    t_pins;
    stop_test;
  end
endmodule : reader_irq_status_flags_test

// >>> test/rirq_host_model.sv
module rirq_host_model (
  // Clock
  input  wire logic       clk,
  // Register port towards the block
  output logic            host_wr,
  output logic            host_rd,
  output logic            host_rd_end,
  output logic      [7:0] host_addr,
  output logic      [7:0] host_wdata,
  // Read data from the block
  input  wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import rirq_pkg::*;

  initial begin
    host_wr     = 1'b0;
    host_rd     = 1'b0;
    host_rd_end = 1'b0;
    host_addr   = 8'hff;
    host_wdata  = 8'h5a;
  end

  // Idle address and data are inverted so nothing stale looks valid
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr    <= 1'b0;
    host_addr  <= ~a;
    host_wdata <= ~d;
  endtask : wr

  task rd(input logic [7:0] a, input logic clr, output logic [7:0] d);
    @(posedge clk);
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
    // Address held across the whole read phase
    if (clr) begin
      @(posedge clk);
      host_rd_end <= 1'b1;
      @(posedge clk);
      host_rd_end <= 1'b0;
    end
    @(posedge clk);
    host_addr <= ~a;
  endtask : rd
endmodule : rirq_host_model
